// ==== core/dbgsc_bkpt_match.sv ====
// dbgsc_bkpt_match: compares the cpu address bus with the match address
// and splits a hit into a forced or a tagged request.
// assumes addr and its qualifiers are synchronous to the same clock.
`timescale 1ns/1ns
`default_nettype none
module dbgsc_bkpt_match #(
  parameter int unsigned AW = 16
) (
  input wire logic en,
  input wire logic force_tag_select,
  input wire logic [AW-1:0] match,
  input wire logic [AW-1:0] addr,
  input wire logic addr_valid,
  input wire logic opfetch,
  output logic force_hit,
  output logic tag_hit
);

  logic hit;

  // disabled matcher never requests anything
  assign hit = en && addr_valid && (addr == match);
  // forced: any access; tagged: opcode fetches only
  assign force_hit = hit && force_tag_select;
  assign tag_hit = hit && !force_tag_select && opfetch;

endmodule
`default_nettype wire

// ==== core/dbgsc_pkg.sv ====
// dbgsc_pkg: constants, command codes and carrier structs for the
// debug status/control and breakpoint match block.
// assumes a decoded command port in front of the serial link.
package dbgsc_pkg;

  // status/control bit positions
  localparam int unsigned BIT_PERMIT = 7;
  localparam int unsigned BIT_ACTIVE = 6;
  localparam int unsigned BIT_BKEN = 5;
  localparam int unsigned BIT_FORCE_TAG = 4;
  localparam int unsigned BIT_CLKSEL = 3;
  localparam int unsigned BIT_LPSTAT = 2;
  localparam int unsigned BIT_LPFAIL = 1;
  localparam int unsigned BIT_DVFAIL = 0;

  // values after a normal reset and after a reset in the debug state
  localparam logic [7:0] RST_SCR_NORMAL = 8'h00;
  localparam logic [7:0] RST_SCR_ACTIVE = 8'hc8;
  localparam logic [15:0] RST_BKPT = 16'h0000;
  localparam logic [1:0] RST_SYNC = 2'h0;

  // command codes
  typedef enum logic [7:0] {
    CMD_GO = 8'h08,
    CMD_HALT = 8'h90,
    CMD_RD_STAT = 8'he4,
    CMD_WR_CTRL = 8'hc4,
    CMD_RD_BKPT = 8'he2,
    CMD_WR_BKPT = 8'hc2
  } dbgsc_code_t;

  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [15:0] data;
  } dbgsc_cmd_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } dbgsc_rsp_t;

  typedef struct packed {
    logic first;
    logic permit;
    logic active;
    logic bken;
    logic force_tag_select;
    logic clksel;
    logic low_power_status;
    logic low_power_failure;
    logic data_valid_failure;
    logic [15:0] bkpt;
    logic force_pend;
    logic tag_out;
    logic rsp_valid;
    logic [15:0] rsp_data;
  } dbgsc_state_t;

endpackage

// ==== core/dbgsc_top.sv ====
// dbgsc_top: debug status/control register, breakpoint match register,
// debug-state flag and breakpoint request logic.
// assumes a serial front end delivering decoded one-cycle commands and a
// cpu that reports low-power state, instruction boundaries and tag hits.
`timescale 1ns/1ns
`default_nettype none

module dbgsc_top #(
  parameter int unsigned AW = 16,
  parameter bit SLOW_MEM = 1'b0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic reset_in_debug,
  input wire dbgsc_pkg::dbgsc_cmd_t cmd,
  output var dbgsc_pkg::dbgsc_rsp_t rsp,
  input wire logic [AW-1:0] cpu_addr,
  input wire logic cpu_addr_valid,
  input wire logic cpu_opfetch,
  input wire logic cpu_insn_boundary,
  input wire logic cpu_tag_exec,
  input wire logic cpu_low_power,
  input wire logic mem_fail_lp,
  input wire logic mem_fail_slow,
  output logic cpu_debug_halt,
  output logic bkpt_tag,
  output logic comm_clk_sel
);

  logic [1:0] rst_sync_r;
  logic rst_n;
  dbgsc_pkg::dbgsc_state_t s_r;
  dbgsc_pkg::dbgsc_state_t s_nxt;
  logic force_hit;
  logic tag_hit;
  logic enter;
  logic leave;
  logic is_cmd;

  function automatic logic [7:0] status_of(
    input dbgsc_pkg::dbgsc_state_t s
  );
    logic [7:0] v;
    v = 8'h00;
    v[dbgsc_pkg::BIT_PERMIT] = s.permit;
    v[dbgsc_pkg::BIT_ACTIVE] = s.active;
    v[dbgsc_pkg::BIT_BKEN] = s.bken;
    v[dbgsc_pkg::BIT_FORCE_TAG] = s.force_tag_select;
    v[dbgsc_pkg::BIT_CLKSEL] = s.clksel;
    v[dbgsc_pkg::BIT_LPSTAT] = s.low_power_status;
    v[dbgsc_pkg::BIT_LPFAIL] = s.low_power_failure;
    v[dbgsc_pkg::BIT_DVFAIL] = s.data_valid_failure;
    return v;
  endfunction

  function automatic logic cmd_is(
    input dbgsc_pkg::dbgsc_cmd_t c,
    input dbgsc_pkg::dbgsc_code_t code
  );
    return c.valid && (c.code == code);
  endfunction

  // reset released through two flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_r <= dbgsc_pkg::RST_SYNC;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  dbgsc_bkpt_match #(
    .AW(AW)
  ) u_match (
    .en(s_r.bken),
    .force_tag_select(s_r.force_tag_select),
    .match(s_r.bkpt),
    .addr(cpu_addr),
    .addr_valid(cpu_addr_valid),
    .opfetch(cpu_opfetch),
    .force_hit(force_hit),
    .tag_hit(tag_hit)
  );

  assign is_cmd = cmd.valid;

  always_comb begin
    s_nxt = s_r;
    s_nxt.first = 1'b0;
    s_nxt.rsp_valid = 1'b0;
    s_nxt.rsp_data = 16'h0000;
    enter = 1'b0;
    leave = 1'b0;
    if (s_r.first && reset_in_debug) begin
      s_nxt.permit = dbgsc_pkg::RST_SCR_ACTIVE[dbgsc_pkg::BIT_PERMIT];
      s_nxt.active = dbgsc_pkg::RST_SCR_ACTIVE[dbgsc_pkg::BIT_ACTIVE];
      s_nxt.clksel = dbgsc_pkg::RST_SCR_ACTIVE[dbgsc_pkg::BIT_CLKSEL];
    end
    // forced hit waits for a boundary
    if (force_hit) begin
      s_nxt.force_pend = 1'b1;
    end
    if (s_r.force_pend && cpu_insn_boundary) begin
      enter = 1'b1;
      s_nxt.force_pend = 1'b0;
    end
    s_nxt.tag_out = tag_hit;
    if (cpu_tag_exec) begin
      enter = 1'b1;
    end
    // registers reached only through this port
    if (is_cmd) begin
      case (cmd.code)
        dbgsc_pkg::CMD_RD_STAT: begin
          s_nxt.rsp_valid = 1'b1;
          s_nxt.rsp_data = {8'h00, status_of(s_r)};
          s_nxt.low_power_failure = 1'b0;
          s_nxt.data_valid_failure = 1'b0;
        end
        dbgsc_pkg::CMD_WR_CTRL: begin
          s_nxt.rsp_valid = 1'b1;
          if (!s_r.active) begin
            s_nxt.permit = s_r.permit | cmd.data[dbgsc_pkg::BIT_PERMIT];
          end
          s_nxt.bken = cmd.data[dbgsc_pkg::BIT_BKEN];
          s_nxt.force_tag_select = cmd.data[dbgsc_pkg::BIT_FORCE_TAG];
          s_nxt.clksel = cmd.data[dbgsc_pkg::BIT_CLKSEL];
        end
        dbgsc_pkg::CMD_RD_BKPT: begin
          s_nxt.rsp_valid = 1'b1;
          s_nxt.rsp_data = s_r.bkpt;
        end
        dbgsc_pkg::CMD_WR_BKPT: begin
          s_nxt.rsp_valid = 1'b1;
          s_nxt.bkpt = cmd.data;
        end
        dbgsc_pkg::CMD_HALT: begin
          s_nxt.rsp_valid = 1'b1;
          enter = 1'b1;
        end
        dbgsc_pkg::CMD_GO: begin
          s_nxt.rsp_valid = 1'b1;
          leave = s_r.active;
        end
        default: begin
          s_nxt.rsp_valid = 1'b0;
        end
      endcase
    end
    if (!s_r.permit || s_r.active) begin
      enter = 1'b0;
    end
    // low-power status live or latched by halt
    if (enter) begin
      s_nxt.active = 1'b1;
      s_nxt.force_pend = 1'b0;
      s_nxt.low_power_status = cpu_low_power;
    end else if (leave) begin
      s_nxt.active = 1'b0;
      s_nxt.low_power_status = cpu_low_power;
    end else begin
      s_nxt.low_power_status = cpu_low_power
        || (s_r.low_power_status && s_r.active);
    end
    // failure flag, set beats read clear
    if (mem_fail_lp) begin
      s_nxt.low_power_failure = 1'b1;
    end
    // only a part with slow memory sets it
    if (SLOW_MEM && mem_fail_slow) begin
      s_nxt.data_valid_failure = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r.first <= 1'b1;
      s_r.permit <= dbgsc_pkg::RST_SCR_NORMAL[dbgsc_pkg::BIT_PERMIT];
      s_r.active <= dbgsc_pkg::RST_SCR_NORMAL[dbgsc_pkg::BIT_ACTIVE];
      s_r.bken <= dbgsc_pkg::RST_SCR_NORMAL[dbgsc_pkg::BIT_BKEN];
      s_r.force_tag_select <=
        dbgsc_pkg::RST_SCR_NORMAL[dbgsc_pkg::BIT_FORCE_TAG];
      s_r.clksel <= dbgsc_pkg::RST_SCR_NORMAL[dbgsc_pkg::BIT_CLKSEL];
      s_r.low_power_status <=
        dbgsc_pkg::RST_SCR_NORMAL[dbgsc_pkg::BIT_LPSTAT];
      s_r.low_power_failure <=
        dbgsc_pkg::RST_SCR_NORMAL[dbgsc_pkg::BIT_LPFAIL];
      s_r.data_valid_failure <=
        dbgsc_pkg::RST_SCR_NORMAL[dbgsc_pkg::BIT_DVFAIL];
      s_r.bkpt <= dbgsc_pkg::RST_BKPT;
      s_r.force_pend <= 1'b0;
      s_r.tag_out <= 1'b0;
      s_r.rsp_valid <= 1'b0;
      s_r.rsp_data <= 16'h0000;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rsp = {s_r.rsp_valid, s_r.rsp_data};
  assign cpu_debug_halt = s_r.active;
  assign bkpt_tag = s_r.tag_out;
  assign comm_clk_sel = s_r.clksel;

  permit_hold_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_r.permit |=> s_r.permit
  ) else $error("permit bit dropped without reset");

  permit_lock_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (s_r.active && cmd_is(cmd, dbgsc_pkg::CMD_WR_CTRL) && !s_r.first)
    |=> s_r.permit == $past(s_r.permit)
  ) else $error("permit changed while in debug state");

  ro_bits_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (cmd_is(cmd, dbgsc_pkg::CMD_WR_CTRL) && !s_r.first && !cpu_tag_exec
     && !(s_r.force_pend && cpu_insn_boundary))
    |=> s_r.active == $past(s_r.active)
  ) else $error("control write altered the active flag");

  clk_sel_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    cmd_is(cmd, dbgsc_pkg::CMD_WR_CTRL)
    |=> comm_clk_sel == $past(cmd.data[dbgsc_pkg::BIT_CLKSEL])
  ) else $error("clock select not taken from control write");

  no_entry_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!s_r.permit && !s_r.active && !s_r.first) |=> !s_r.active
  ) else $error("debug state entered without permit");

  halt_entry_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (cmd_is(cmd, dbgsc_pkg::CMD_HALT) && s_r.permit && cpu_low_power)
    |=> cpu_debug_halt && s_r.low_power_status
  ) else $error("halt from low power not taken");

  bp_off_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!s_r.bken && !s_r.force_pend) |=> !s_r.force_pend && !bkpt_tag
  ) else $error("breakpoint requested while disabled");

  force_entry_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (s_r.force_pend && cpu_insn_boundary && s_r.permit)
    |=> cpu_debug_halt
  ) else $error("forced break did not halt at boundary");

  tag_entry_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (s_r.bken && !s_r.force_tag_select && cpu_addr_valid && cpu_opfetch
     && cpu_addr == s_r.bkpt) |=> bkpt_tag
  ) else $error("opcode at match address not tagged");

  lp_stat_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (cpu_low_power && !s_r.first) |=> s_r.low_power_status
  ) else $error("low-power status missing");

  lp_fail_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    mem_fail_lp |=> s_r.low_power_failure ##1 (s_r.low_power_failure ||
      $past(cmd_is(cmd, dbgsc_pkg::CMD_RD_STAT)))
  ) else $error("low-power failure flag not held");

  dv_fail_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !SLOW_MEM |-> !s_r.data_valid_failure
  ) else $error("data-valid failure set without slow memory");

  stat_read_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    cmd_is(cmd, dbgsc_pkg::CMD_RD_STAT)
    |=> rsp.valid && rsp.data == {8'h00, $past(status_of(s_r))}
  ) else $error("status read returned wrong byte");

endmodule
`default_nettype wire

// ==== tb/dbgsc_host.sv ====
// dbgsc_host: debug host model issuing decoded commands to the block.
// assumes the command port is sampled on the rising edge of clk.
`timescale 1ns/1ns
`default_nettype none
module dbgsc_host (
  input wire logic clk,
  output var dbgsc_pkg::dbgsc_cmd_t cmd,
  input wire dbgsc_pkg::dbgsc_rsp_t rsp
);
  initial cmd = '0;

  task automatic xfer(input logic [7:0] code, input logic [15:0] d,
      output logic ok, output logic [15:0] q);
    @(negedge clk);
    cmd <= '{valid: 1'b1, code: code, data: d};
    @(negedge clk);
    ok = rsp.valid;
    q = rsp.data;
    // released fields must not keep looking like a command
    cmd <= '{valid: 1'b0, code: ~code, data: ~d};
  endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// testbench: directed scenarios for the debug status/control block.
// assumes the host model dbgsc_host and the core sources.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module testbench;
  logic clk, nrst, rid, av, of, ib, te, lp, fl, fs;
  logic halt, tag, csel, ok;
  logic [15:0] addr, q;
  dbgsc_pkg::dbgsc_cmd_t cmd;
  dbgsc_pkg::dbgsc_rsp_t rsp;
  int num_errors = 0;
  int n_checks = 0;

  dbgsc_top dut_u (
    .clk(clk), .nrst(nrst), .reset_in_debug(rid), .cmd(cmd), .rsp(rsp),
    .cpu_addr(addr), .cpu_addr_valid(av), .cpu_opfetch(of),
    .cpu_insn_boundary(ib), .cpu_tag_exec(te), .cpu_low_power(lp),
    .mem_fail_lp(fl), .mem_fail_slow(fs), .cpu_debug_halt(halt),
    .bkpt_tag(tag), .comm_clk_sel(csel)
  );
  dbgsc_host host_u (.clk(clk), .cmd(cmd), .rsp(rsp));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic cmd_do(input logic [7:0] c, input logic [15:0] d);
    host_u.xfer(c, d, ok, q);
    `CHK(ok, 1'b1)
  endtask

  task automatic stat(input logic [7:0] e);
    cmd_do(8'he4, 16'h0000);
    `CHK(q, {8'h00, e})
  endtask

  task automatic do_reset(input logic d);
    @(negedge clk);
    nrst = 1'b0;
    rid = d;
    cyc(3);
    nrst = 1'b1;
    cyc(4);
  endtask

  task automatic hit(input logic [15:0] a, input logic f);
    @(negedge clk);
    addr = a;
    av = 1'b1;
    of = f;
    @(negedge clk);
    av = 1'b0;
    of = 1'b0;
    addr = ~a;
  endtask

  // one-cycle pulse: 0 boundary, 1 tag exec, 2 lp fail, 3 slow fail
  task automatic strobe(input int w);
    @(negedge clk);
    {fs, fl, te, ib} = 4'h1 << w;
    @(negedge clk);
    {fs, fl, te, ib} = 4'h0;
  endtask

  task automatic t_reset();
    stat(8'h00);
    cmd_do(8'he2, 16'h0000);
    `CHK(q, 16'h0000)
    `CHK(csel, 1'b0)
    host_u.xfer(8'h55, 16'h0000, ok, q);
    `CHK(ok, 1'b0)
  endtask

  task automatic t_permit_off();
    cmd_do(8'h90, 16'h0000);
    cyc(2);
    `CHK(halt, 1'b0)
    stat(8'h00);
  endtask

  task automatic t_ctrl();
    cmd_do(8'hc4, 16'hffff);
    stat(8'hb8);
    `CHK(csel, 1'b1)
    cmd_do(8'hc4, 16'h0000);
    stat(8'h80);
    `CHK(csel, 1'b0)
  endtask

  task automatic t_match();
    cmd_do(8'hc2, 16'ha5c3);
    cmd_do(8'he2, 16'h0000);
    `CHK(q, 16'ha5c3)
  endtask

  task automatic t_off();
    cmd_do(8'hc4, 16'h0090);
    hit(16'ha5c3, 1'b1);
    `CHK(tag, 1'b0)
    strobe(0);
    cyc(1);
    `CHK(halt, 1'b0)
  endtask

  task automatic t_force();
    cmd_do(8'hc4, 16'h00b0);
    hit(16'ha5c2, 1'b1);
    strobe(0);
    cyc(1);
    `CHK(halt, 1'b0)
    hit(16'ha5c3, 1'b0);
    cyc(2);
    `CHK(halt, 1'b0)
    strobe(0);
    cyc(1);
    `CHK(halt, 1'b1)
    stat(8'hf0);
    cmd_do(8'hc4, 16'h0030);
    stat(8'hf0);
    cmd_do(8'h08, 16'h0000);
    cyc(1);
    `CHK(halt, 1'b0)
    stat(8'hb0);
  endtask

  task automatic t_tag();
    cmd_do(8'hc4, 16'h00a0);
    hit(16'ha5c3, 1'b1);
    `CHK(tag, 1'b1)
    cyc(1);
    `CHK(tag, 1'b0)
    `CHK(halt, 1'b0)
    strobe(1);
    cyc(1);
    `CHK(halt, 1'b1)
    cmd_do(8'h08, 16'h0000);
  endtask

  task automatic t_lowpow();
    cmd_do(8'hc4, 16'h0080);
    lp = 1'b1;
    cyc(2);
    stat(8'h84);
    strobe(2);
    stat(8'h86);
    cmd_do(8'h90, 16'h0000);
    cyc(1);
    `CHK(halt, 1'b1)
    stat(8'hc4);
    lp = 1'b0;
    cyc(2);
    stat(8'hc4);
    cmd_do(8'h08, 16'h0000);
    cyc(1);
    stat(8'h80);
    strobe(3);
    stat(8'h80);
  endtask

  initial begin
    {nrst, rid, av, of, ib, te, lp, fl, fs} = '0;
    addr = 16'h0000;
    do_reset(1'b0);
    t_reset();
    t_permit_off();
    t_ctrl();
    t_match();
    t_off();
    t_force();
    t_tag();
    t_lowpow();
    do_reset(1'b1);
    stat(8'hc8);
    `CHK(halt, 1'b1)
    `CHK(csel, 1'b1)
    final_report();
  end

  initial begin
    #200000;
    num_errors++;
    final_report();
  end
endmodule
`default_nettype wire
